// file: hdl/ohcid_pkg.sv
// Purpose: Shared constants and carrier types for the interrupt disable port block.
// Assumes: 32-bit register word; one access per clock cycle.
// Notes: Offsets are relative to the memory base held in configuration space.
package ohcid_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 32;

   // Register offsets from the memory base
   localparam logic [ADDR_W-1:0] OFS_ENABLE = 32'h0000_0010;
   localparam logic [ADDR_W-1:0] OFS_DISABLE = 32'h0000_0014;
   // Configuration space offset of the memory base (for reference)
   localparam logic [7:0] CFG_MEM_BASE_OFS = 8'h10;

   // Field positions
   localparam int unsigned POS_MASTER = 31;
   localparam int unsigned POS_OWNERSHIP = 30;
   localparam int unsigned POS_ROOT_HUB = 6;
   localparam int unsigned POS_FRAME_OVF = 5;
   localparam int unsigned POS_UNRECOV = 4;
   localparam int unsigned POS_RESUME = 3;
   localparam int unsigned POS_SOF = 2;
   localparam int unsigned POS_DONE_HEAD = 1;
   localparam int unsigned POS_SCHED_OVR = 0;

   // Implemented bits: 31, 30 and 6..0; the rest are reserved
   localparam logic [DATA_W-1:0] IMPL_BITS = 32'hC000_007F;
   // Event enables without the master gate
   localparam logic [DATA_W-1:0] EVENT_BITS = 32'h4000_007F;
   localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ohcid_req_type;

   typedef struct packed {
      logic ack;
      logic [DATA_W-1:0] rdata;
   } ohcid_rsp_type;

endpackage : ohcid_pkg

// file: hdl/ohcid_mask_store.sv
// Purpose: Storage of the interrupt enable mask with per-bit set and clear.
// Assumes: Set and clear come from the same register access decode.
// Notes: Only implemented bit positions hold state; the rest stay zero.
`timescale 1ns/10ps
`default_nettype none
module ohcid_mask_store #(
   parameter int unsigned WIDTH = 32,
   parameter logic [WIDTH-1:0] IMPL = '1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Bit updates
   input wire logic [WIDTH-1:0] set_bits,
   input wire logic [WIDTH-1:0] clr_bits,
   // Stored mask
   output logic [WIDTH-1:0] mask
);

   wire logic [WIDTH-1:0] next_mask;

   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         if (IMPL[b]) begin : g_impl
            // A set wins over a clear in the same cycle
            assign next_mask[b] = set_bits[b] | (mask[b] & ~clr_bits[b]);
         end else begin : g_rsvd
            assign next_mask[b] = 1'b0;
         end
      end
   endgenerate

   // One register for the whole word keeps a single writer per variable
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask <= RESET_VAL & IMPL;
      end else begin
         mask <= next_mask;
      end
   end

endmodule : ohcid_mask_store
`default_nettype wire

// file: hdl/ohcid_irq_disable.sv
// Purpose: Interrupt enable mask with its write-one-to-clear disable port.
// Assumes: Register accesses arrive decoded to one 32-bit word per cycle.
`timescale 1ns/10ps
`default_nettype none
module ohcid_irq_disable #(
   parameter int unsigned WIDTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Memory base from configuration offset 10h
   input wire logic [ohcid_pkg::ADDR_W-1:0] mem_base,
   // Register access request and answer
   input wire ohcid_pkg::ohcid_req_type acc_req,
   output ohcid_pkg::ohcid_rsp_type acc_rsp,
   // Interrupt status flags from the controller
   input wire logic [WIDTH-1:0] interrupt_status_flags,
   // Registered mask copy one clock behind the store, and host bus interrupt request
   output logic [WIDTH-1:0] interrupt_enable_mask,
   output logic irq_req
);
   import ohcid_pkg::*;

   // Address decode
   wire logic [ADDR_W-1:0] rel_addr;
   wire logic hit_enable;
   wire logic hit_disable;
   wire logic hit_any;
   wire logic wr_enable;
   wire logic wr_disable;
   wire logic [WIDTH-1:0] wdata_impl;
   wire logic [WIDTH-1:0] set_bits;
   wire logic [WIDTH-1:0] clr_bits;
   wire logic [WIDTH-1:0] mask;
   wire logic [WIDTH-1:0] pending;
   wire logic next_irq;
   wire ohcid_rsp_type next_rsp;

   assign rel_addr = acc_req.addr - mem_base;
   assign hit_enable = acc_req.valid && (rel_addr == OFS_ENABLE);
   assign hit_disable = acc_req.valid && (rel_addr == OFS_DISABLE);
   assign hit_any = hit_enable | hit_disable;
   assign wr_enable = hit_enable & acc_req.write;
   assign wr_disable = hit_disable & acc_req.write;

   // Whole word taken; reserved positions are dropped
   assign wdata_impl = acc_req.wdata & IMPL_BITS;

   // Same bit index on both ports and in the status flags
   assign set_bits = wr_enable ? wdata_impl : ZERO_WORD;
   // Ones clear, zeros leave bits alone
   assign clr_bits = wr_disable ? wdata_impl : ZERO_WORD;

   ohcid_mask_store #(
      .WIDTH(WIDTH),
      .IMPL(IMPL_BITS),
      .RESET_VAL(MASK_RESET)
   ) ohcid_mask_store_inst (
      .clk(clk),
      .rstn(rstn),
      .set_bits(set_bits),
      .clr_bits(clr_bits),
      .mask(mask)
   );

   // Gate events by their enable and then by the master gate
   assign pending = interrupt_status_flags & mask & EVENT_BITS;
   assign next_irq = mask[POS_MASTER] & (|pending);

   // Either port reads back the shared mask
   assign next_rsp = '{
      ack: hit_any,
      rdata: (hit_any && !acc_req.write) ? mask : ZERO_WORD
   };

   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc_rsp <= '0;
         irq_req <= 1'b0;
         interrupt_enable_mask <= MASK_RESET;
      end else begin
         acc_rsp <= next_rsp;
         irq_req <= next_irq;
         interrupt_enable_mask <= mask;
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic [WIDTH-1:0] chk_wdata;
   logic [WIDTH-1:0] chk_mask;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         chk_wdata <= '0;
         chk_mask <= '0;
      end else begin
         chk_wdata <= acc_req.wdata;
         chk_mask <= mask;
      end
   end

   sequence s_gate_write;
      wr_disable && acc_req.wdata[POS_MASTER];
   endsequence

   sequence s_gate_off;
      !mask[POS_MASTER] ##1 !irq_req;
   endsequence

   sequence s_read_dis;
      hit_disable && !acc_req.write;
   endsequence

   clear_ones_a: assert property (
      wr_disable |=> (mask & chk_wdata & IMPL_BITS) == ZERO_WORD)
      else $error("disable write left a written-one enable bit set");

   keep_zeros_a: assert property (
      wr_disable |=> mask == (chk_mask & ~(chk_wdata & IMPL_BITS)))
      else $error("disable write changed a bit written as zero");

   read_back_a: assert property (
      s_read_dis |=> acc_rsp.ack && acc_rsp.rdata == chk_mask)
      else $error("disable port read did not return the enable mask");

   bit_map_a: assert property (
      wr_enable |=> mask == (chk_mask | (chk_wdata & IMPL_BITS)))
      else $error("enable and disable bit positions do not line up");

   word_ack_a: assert property (
      hit_any |=> acc_rsp.ack ##1 !acc_rsp.ack || $past(hit_any))
      else $error("register access not answered as one word");

   base_decode_a: assert property (
      acc_req.valid && (acc_req.addr != mem_base + OFS_DISABLE)
         && (acc_req.addr != mem_base + OFS_ENABLE) |=> !acc_rsp.ack)
      else $error("access outside the mapped offsets was answered");

   gate_clear_a: assert property (
      s_gate_write |=> s_gate_off)
      else $error("master gate clear did not stop the interrupt");

   layout_a: assert property (
      (mask & ~IMPL_BITS) == ZERO_WORD)
      else $error("enable bit set outside its documented positions");

   irq_gate_a: assert property (
      ##1 irq_req == $past(mask[POS_MASTER] && |(interrupt_status_flags & mask & EVENT_BITS)))
      else $error("interrupt request does not follow flag, enable and gate");

   sequence s_miss;
      acc_req.valid && !hit_any;
   endsequence

   sequence s_read_any;
      hit_any && !acc_req.write;
   endsequence

   // Reset is checked outside the default disable so that it is seen at all
   reset_clears_a: assert property (disable iff (1'b0)
      !rstn |=> !acc_rsp.ack && !irq_req && mask == MASK_RESET
         && interrupt_enable_mask == MASK_RESET)
      else $error("reset left the mask, answer or interrupt active");

   miss_keeps_a: assert property (
      s_miss |=> mask == chk_mask)
      else $error("access outside the mapped offsets changed the mask");

   read_keeps_a: assert property (
      s_read_any |=> mask == chk_mask)
      else $error("register read changed the mask");

   enable_read_a: assert property (
      hit_enable && !acc_req.write |=> acc_rsp.rdata == chk_mask)
      else $error("enable port read did not return the shared mask");

   write_quiet_a: assert property (
      hit_any && acc_req.write |=> acc_rsp.ack && acc_rsp.rdata == ZERO_WORD)
      else $error("write answer carried read data");

   idle_quiet_a: assert property (
      !acc_req.valid |=> !acc_rsp.ack)
      else $error("answer given without a request");

   mask_copy_a: assert property (
      interrupt_enable_mask == chk_mask)
      else $error("mask output does not follow the stored mask");

   gate_kept_a: assert property (
      wr_disable && !acc_req.wdata[POS_MASTER] |=> mask[POS_MASTER] == chk_mask[POS_MASTER])
      else $error("master gate changed by a disable write of zero");

   owner_clear_a: assert property (
      wr_disable && acc_req.wdata[POS_OWNERSHIP] |=> !mask[POS_OWNERSHIP])
      else $error("ownership change enable not cleared by its disable bit");

   hub_clear_a: assert property (
      wr_disable && acc_req.wdata[POS_ROOT_HUB] |=> !mask[POS_ROOT_HUB])
      else $error("root hub change enable not cleared by its disable bit");

   gate_blocks_a: assert property (
      !mask[POS_MASTER] |=> !irq_req)
      else $error("interrupt requested with the master gate clear");

   no_event_a: assert property (
      (interrupt_status_flags & mask & EVENT_BITS) == ZERO_WORD |=> !irq_req)
      else $error("interrupt requested with no enabled flag set");

   irq_cause_a: assert property (
      irq_req |-> $past(mask[POS_MASTER]))
      else $error("interrupt request without the master gate set before");

endmodule : ohcid_irq_disable
`default_nettype wire

// file: tb/ohcid_host.sv
// Purpose: Host software model issuing register accesses.
// Assumes: One access at a time; the answer is awaited before the next.
// Notes: Released request lines carry the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none
module ohcid_host (
   // Clock
   input wire logic clk,
   // Register bus
   input wire logic [ohcid_pkg::ADDR_W-1:0] mem_base,
   input wire ohcid_pkg::ohcid_rsp_type acc_rsp,
   output ohcid_pkg::ohcid_req_type acc_req
);
   import ohcid_pkg::*;
   initial acc_req = '0;
   task automatic access(input logic wr, input logic [ADDR_W-1:0] ofs,
         input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd, output logic ok);
      ok = 1'b0;
      rd = ~wd;
      @(negedge clk);
      acc_req = '{1'b1, wr, mem_base + ofs, wd};
      @(negedge clk);
      acc_req = '{1'b0, ~wr, ~(mem_base + ofs), ~wd};
      repeat (2) begin
         if (!ok && acc_rsp.ack === 1'b1) begin
            ok = 1'b1;
            rd = acc_rsp.rdata;
         end
         @(negedge clk);
      end
   endtask : access
endmodule : ohcid_host
`default_nettype wire

// file: tb/tb_ohcid_irq_disable.sv
// Purpose: Self-checking bench for the interrupt disable port.
// Assumes: Inputs change at the falling edge.
// Notes: Register accesses go through the host model.
`timescale 1ns/10ps
`default_nettype none
module tb_ohcid_irq_disable;
   import ohcid_pkg::*;
   localparam logic [ADDR_W-1:0] BASE = 32'hFEB0_0000;
   logic clk, rstn, irq, ok;
   logic [ADDR_W-1:0] mem_base;
   logic [DATA_W-1:0] flags, mask, rd, expv;
   ohcid_req_type acc_req;
   ohcid_rsp_type acc_rsp;
   int fail_count, cmp_count;
   ohcid_irq_disable ohcid_irq_disable_inst (.clk(clk), .rstn(rstn), .mem_base(mem_base),
      .acc_req(acc_req), .acc_rsp(acc_rsp), .interrupt_status_flags(flags),
      .interrupt_enable_mask(mask), .irq_req(irq));
   ohcid_host ohcid_host_inst (.clk(clk), .mem_base(mem_base), .acc_rsp(acc_rsp),
      .acc_req(acc_req));
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rw(input logic wr, input logic [ADDR_W-1:0] ofs, input logic [DATA_W-1:0] wd);
      ohcid_host_inst.access(wr, ofs, wd, rd, ok);
      chk({31'h0, ok}, 32'h1);
   endtask : rw
   task automatic irq_is(input logic v);
      repeat (2) @(negedge clk);
      chk({31'h0, irq}, {31'h0, v});
   endtask : irq_is
   task automatic t_reset;
      rw(1'b0, OFS_DISABLE, ZERO_WORD);
      chk(rd, MASK_RESET);
      chk({31'h0, irq}, ZERO_WORD);
   endtask : t_reset
   task automatic t_clear;
      int pos[8] = '{0, 1, 2, 3, 4, 5, 6, 30};
      rw(1'b1, OFS_ENABLE, 32'hFFFF_FFFF);
      rw(1'b0, OFS_DISABLE, ZERO_WORD);
      chk(rd, IMPL_BITS);
      expv = IMPL_BITS;
      foreach (pos[i]) begin
         rw(1'b1, OFS_DISABLE, 32'h1 << pos[i]);
         chk(rd, ZERO_WORD);
         expv[pos[i]] = 1'b0;
         rw(1'b0, OFS_DISABLE, ZERO_WORD);
         chk(rd, expv);
         chk(mask, expv);
      end
   endtask : t_clear
   task automatic t_irq;
      rw(1'b1, OFS_ENABLE, IMPL_BITS);
      flags = 32'h1 << POS_SOF;
      irq_is(1'b1);
      rw(1'b1, OFS_DISABLE, 32'h8000_0000);
      irq_is(1'b0);
      rw(1'b1, OFS_ENABLE, 32'h8000_0000);
      irq_is(1'b1);
      rw(1'b1, OFS_DISABLE, 32'h1 << POS_SOF);
      irq_is(1'b0);
      flags = ZERO_WORD;
   endtask : t_irq
   task automatic t_miss;
      ohcid_host_inst.access(1'b1, 32'h0000_0018, 32'hFFFF_FFFF, rd, ok);
      chk({31'h0, ok}, ZERO_WORD);
      rw(1'b0, OFS_DISABLE, ZERO_WORD);
      chk(rd, IMPL_BITS & ~(32'h1 << POS_SOF));
   endtask : t_miss
   task automatic t_base;
      mem_base = BASE + 32'h0000_1000;
      expv = IMPL_BITS & ~(32'h1 << POS_SOF) & ~(32'h1 << POS_OWNERSHIP);
      rw(1'b1, OFS_DISABLE, 32'h1 << POS_OWNERSHIP);
      ohcid_host_inst.access(1'b0, OFS_DISABLE - 32'h0000_1000, ZERO_WORD, rd, ok);
      chk({31'h0, ok}, ZERO_WORD);
      rw(1'b0, OFS_ENABLE, ZERO_WORD);
      chk(rd, expv);
      rw(1'b0, OFS_DISABLE, ZERO_WORD);
      chk(rd, expv);
      mem_base = BASE;
   endtask : t_base
   task automatic t_rst_mid;
      rw(1'b1, OFS_ENABLE, IMPL_BITS);
      flags = IMPL_BITS;
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      chk(mask, MASK_RESET);
      chk({31'h0, irq}, ZERO_WORD);
      rw(1'b0, OFS_DISABLE, ZERO_WORD);
      chk(rd, MASK_RESET);
      chk({31'h0, irq}, ZERO_WORD);
      flags = ZERO_WORD;
   endtask : t_rst_mid
   task automatic summarize;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #20000;
      fail_count++;
      summarize();
   end
   initial begin
      rstn = 1'b0;
      flags = ZERO_WORD;
      mem_base = BASE;
      fail_count = 0;
      cmp_count = 0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      t_reset();
      t_clear();
      t_irq();
      t_miss();
      t_base();
      t_rst_mid();
      summarize();
   end
endmodule : tb_ohcid_irq_disable
`default_nettype wire
